//--- hdl/eim_defs.vh
`ifndef EIM_DEFS_VH
`define EIM_DEFS_VH

// ---------------------------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------------------------
`define EIM_OFF_STATUS 32'hfffbc024
`define EIM_OFF_ENABLE 32'hfffbc028
`define EIM_OFF_DISABLE 32'hfffbc02c
`define EIM_OFF_MASK 32'hfffbc030
`define EIM_OFF_PEEK 32'hfffbc0f8
`define EIM_OFF_CLEAR 32'hfffbc0fc

// ---------------------------------------------------------------
// Source bit positions
// ---------------------------------------------------------------
`define EIM_BIT_MGMT 0
`define EIM_BIT_RXSTORED 1
`define EIM_BIT_RXUSED 2
`define EIM_BIT_TXUSED 3
`define EIM_BIT_TXUNDER 4
`define EIM_BIT_RETRY 5
`define EIM_BIT_TXEXH 6
`define EIM_BIT_TXSENT 7
`define EIM_BIT_RXOVR 10
`define EIM_BIT_BUSERR 11
`define EIM_BIT_PAUSE 12
`define EIM_BIT_PTZERO 13
`define EIM_BIT_WAKE 14

// ---------------------------------------------------------------
// Widths and constant values
// ---------------------------------------------------------------
`define EIM_NSRC 15
`define EIM_SRC_MSB 14
`define EIM_SRC_VALID 15'h7cff
`define EIM_SRC_ZERO 15'h0000
`define EIM_PAD_ZERO 17'h00000
`define EIM_WORD_ZERO 32'h00000000

`endif

//--- hdl/eim_flag_bank.v
`timescale 1ns/1ns
`default_nettype none
`include "eim_defs.vh"

module eim_flag_bank (
	input wire core_clk,
	input wire rst_b,
	input wire clk_en,
	input wire [`EIM_SRC_MSB:0] set_vec,
	input wire [`EIM_SRC_MSB:0] clr_vec,
	output reg [`EIM_SRC_MSB:0] flags_reg
);

// ---------------------------------------------------------------
// Sticky flags
// ---------------------------------------------------------------
// Set is or-ed after the clear so an event in the clearing cycle survives
wire [`EIM_SRC_MSB:0] flags_next;
assign flags_next = ((flags_reg & ~clr_vec) | set_vec) & `EIM_SRC_VALID;

always @(posedge core_clk or negedge rst_b) begin
	if (!rst_b) begin
		flags_reg <= `EIM_SRC_ZERO;
	end else if (clk_en) begin
		flags_reg <= flags_next;
	end
end

endmodule // eim_flag_bank
`default_nettype wire

//--- hdl/eim_irq_mask.v
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "eim_defs.vh"

module eim_irq_mask (
	input wire core_clk,
	input wire rst_b,
	input wire clk_en,
	input wire [31:0] bus_addr,
	input wire [31:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	output reg [31:0] bus_rdata,
	input wire mgmt_frame_done,
	input wire rx_frame_stored,
	input wire rx_desc_used_seen,
	input wire tx_desc_used_seen,
	input wire tx_underrun,
	input wire retry_limit_hit,
	input wire tx_buffers_exhausted,
	input wire tx_frame_sent,
	input wire rx_overrun,
	input wire dma_bus_error,
	input wire pause_frame_seen,
	input wire pause_time_zero,
	input wire wake_event_pin,
	output wire mac_irq
);

// ---------------------------------------------------------------
// Helpers
// ---------------------------------------------------------------
function hit;
	input [31:0] addr;
	input [31:0] offset;
	begin
		hit = (addr == offset);
	end
endfunction

function [31:0] widen;
	input [`EIM_SRC_MSB:0] v;
	begin
		widen = {`EIM_PAD_ZERO, v};
	end
endfunction

// ---------------------------------------------------------------
// Address decode
// ---------------------------------------------------------------
wire wr_enable;
wire wr_disable;
wire wr_clear;
wire rd_status;
wire [`EIM_SRC_MSB:0] wr_bits;

assign wr_enable = bus_wr & hit(bus_addr, `EIM_OFF_ENABLE);
assign wr_disable = bus_wr & hit(bus_addr, `EIM_OFF_DISABLE);
assign wr_clear = bus_wr & hit(bus_addr, `EIM_OFF_CLEAR);
assign rd_status = bus_rd & hit(bus_addr, `EIM_OFF_STATUS);
// Reserved bits 8, 9 and above 14 never reach any register
assign wr_bits = bus_wdata[`EIM_SRC_MSB:0] & `EIM_SRC_VALID;

// ---------------------------------------------------------------
// Wake pin synchroniser
// ---------------------------------------------------------------
// Wake can fire while the MAC clock is off, so it arrives asynchronously
reg wake_meta_reg;
reg wake_sync_reg;
reg wake_prev_reg;
wire wake_rise;

always @(posedge core_clk or negedge rst_b) begin
	if (!rst_b) begin
		wake_meta_reg <= 1'b0;
		wake_sync_reg <= 1'b0;
		wake_prev_reg <= 1'b0;
	end else if (clk_en) begin
		wake_meta_reg <= wake_event_pin;
		wake_sync_reg <= wake_meta_reg;
		wake_prev_reg <= wake_sync_reg;
	end
end

assign wake_rise = wake_sync_reg & ~wake_prev_reg;

// ---------------------------------------------------------------
// Event vector
// ---------------------------------------------------------------
reg [`EIM_SRC_MSB:0] event_vec;

always @* begin
	event_vec = `EIM_SRC_ZERO;
	event_vec[`EIM_BIT_MGMT] = mgmt_frame_done;
	event_vec[`EIM_BIT_RXSTORED] = rx_frame_stored;
	event_vec[`EIM_BIT_RXUSED] = rx_desc_used_seen;
	event_vec[`EIM_BIT_TXUSED] = tx_desc_used_seen;
	event_vec[`EIM_BIT_TXUNDER] = tx_underrun;
	event_vec[`EIM_BIT_RETRY] = retry_limit_hit;
	event_vec[`EIM_BIT_TXEXH] = tx_buffers_exhausted;
	event_vec[`EIM_BIT_TXSENT] = tx_frame_sent;
	event_vec[`EIM_BIT_RXOVR] = rx_overrun;
	event_vec[`EIM_BIT_BUSERR] = dma_bus_error;
	event_vec[`EIM_BIT_PAUSE] = pause_frame_seen;
	event_vec[`EIM_BIT_PTZERO] = pause_time_zero;
	event_vec[`EIM_BIT_WAKE] = wake_rise;
end

// ---------------------------------------------------------------
// Status flags
// ---------------------------------------------------------------
wire [`EIM_SRC_MSB:0] flags;
wire [`EIM_SRC_MSB:0] flag_clr;

// A status read clears every flag; the clear register clears chosen ones
assign flag_clr = rd_status ? `EIM_SRC_VALID : (wr_clear ? wr_bits : `EIM_SRC_ZERO);

eim_flag_bank u_flags (
	.core_clk(core_clk),
	.rst_b(rst_b),
	.clk_en(clk_en),
	.set_vec(event_vec),
	.clr_vec(flag_clr),
	.flags_reg(flags)
);

// ---------------------------------------------------------------
// Mask state register
// ---------------------------------------------------------------
// One means the source may interrupt; reset leaves everything masked
reg [`EIM_SRC_MSB:0] mask_reg;
reg [`EIM_SRC_MSB:0] mask_next;

always @* begin
	mask_next = mask_reg;
	if (wr_enable) begin
		mask_next = mask_reg | wr_bits;
	end
	if (wr_disable) begin
		mask_next = mask_reg & ~wr_bits;
	end
end

always @(posedge core_clk or negedge rst_b) begin
	if (!rst_b) begin
		mask_reg <= `EIM_SRC_ZERO;
	end else if (clk_en) begin
		mask_reg <= mask_next;
	end
end

// ---------------------------------------------------------------
// Interrupt output
// ---------------------------------------------------------------
assign mac_irq = |(flags & mask_reg);

// ---------------------------------------------------------------
// Read path
// ---------------------------------------------------------------
// Write-only and unmapped addresses read as zero
reg [31:0] rdata_next;

always @* begin
	rdata_next = `EIM_WORD_ZERO;
	if (hit(bus_addr, `EIM_OFF_STATUS)) begin
		rdata_next = widen(flags);
	end else if (hit(bus_addr, `EIM_OFF_MASK)) begin
		rdata_next = widen(mask_reg);
	end else if (hit(bus_addr, `EIM_OFF_PEEK)) begin
		rdata_next = widen(flags);
	end
end

always @(posedge core_clk or negedge rst_b) begin
	if (!rst_b) begin
		bus_rdata <= `EIM_WORD_ZERO;
	end else if (clk_en) begin
		bus_rdata <= bus_rd ? rdata_next : `EIM_WORD_ZERO;
	end
end

endmodule // eim_irq_mask
`default_nettype wire

//--- hdl/unused_placeholder_never.v
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

//--- verification/eim_irq_mask_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "eim_defs.vh"
module eim_props (
	input wire core_clk,
	input wire rst_b,
	input wire clk_en,
	input wire [31:0] bus_addr,
	input wire [31:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	input wire [31:0] bus_rdata,
	input wire tx_frame_sent,
	input wire mac_irq
);
	wire ew = clk_en && bus_wr && bus_addr == `EIM_OFF_ENABLE;
	wire da = clk_en && bus_wr && bus_addr == `EIM_OFF_DISABLE
		&& bus_wdata == 32'h7cff;
	wire mr = clk_en && bus_rd && bus_addr == `EIM_OFF_MASK;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// ------
	// Checks
	// ------
	rd_idle_a: assert property (clk_en && !bus_rd |=> bus_rdata == 0)
		else $error("read data not idle");
	rsv_zero_a: assert property ((bus_rdata & 32'hffff8300) == 0)
		else $error("reserved bits set");
	dis_clr_a: assert property (
		da ##1 !bus_wr ##1 mr |=> bus_rdata == 0) else $error("mask kept");
	en_set_a: assert property (
		ew ##1 !bus_wr ##1 mr |=> (~bus_rdata & $past(bus_wdata, 3)
		& 32'h7cff) == 0) else $error("mask not set");
	dis_irq_a: assert property (da |=> !mac_irq)
		else $error("irq while masked");
	irq_off_a: assert property (mr ##1 bus_rdata == 0 |-> !mac_irq)
		else $error("irq with mask zero");
	flag_set_a: assert property (
		clk_en && tx_frame_sent ##1 clk_en && bus_rd
		&& bus_addr == `EIM_OFF_PEEK |=> bus_rdata[7]) else $error("no flag");
	irq_on_a: assert property (
		ew && bus_wdata[7] ##1 clk_en && tx_frame_sent && !bus_wr |=> mac_irq)
		else $error("irq not raised");
endmodule // eim_props
bind eim_irq_mask eim_props eim_props_inst (
	.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
	.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
	.bus_rd(bus_rd), .bus_rdata(bus_rdata),
	.tx_frame_sent(tx_frame_sent), .mac_irq(mac_irq));
`default_nettype wire

//--- verification/tb_eim_irq_mask.sv
`timescale 1ns/1ns
`default_nettype none
`include "eim_defs.vh"
module tb_eim_irq_mask;
	logic core_clk = 0, rst_b = 0, clk_en = 1, bus_wr = 0, bus_rd = 0;
	logic [31:0] bus_addr = 0, bus_wdata = 0, v;
	logic [14:0] ev = 0;
	wire [31:0] bus_rdata;
	wire mac_irq;
	int n_fail = 0, n_compared = 0;
	// Source bit beside its peek flag; wake lags behind its synchroniser
	int rows [13][2] = '{'{0, 1}, '{1, 1}, '{2, 1}, '{3, 1}, '{4, 1},
		'{5, 1}, '{6, 1}, '{7, 1}, '{10, 1}, '{11, 1}, '{12, 1}, '{13, 1}, '{14, 0}};
	eim_irq_mask eim_irq_mask_inst (.core_clk(core_clk), .rst_b(rst_b),
		.clk_en(clk_en), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.mgmt_frame_done(ev[0]), .rx_frame_stored(ev[1]),
		.rx_desc_used_seen(ev[2]), .tx_desc_used_seen(ev[3]),
		.tx_underrun(ev[4]), .retry_limit_hit(ev[5]),
		.tx_buffers_exhausted(ev[6]), .tx_frame_sent(ev[7]),
		.rx_overrun(ev[10]), .dma_bus_error(ev[11]),
		.pause_frame_seen(ev[12]), .pause_time_zero(ev[13]),
		.wake_event_pin(ev[14]), .mac_irq(mac_irq));
	// ---------
	// Bus tasks
	// ---------
	task chk(input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [31:0] a, d);
		@(posedge core_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1;
		@(posedge core_clk);
		bus_wr <= 0;
	endtask
	task rd(input logic [31:0] a, exp);
		@(posedge core_clk);
		bus_addr <= a;
		bus_rd <= 1;
		@(posedge core_clk);
		bus_rd <= 0;
		#1 chk(bus_rdata, exp);
	endtask
	task finish_test;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial forever #50 core_clk = ~core_clk;
	initial begin
		#300000;
		n_fail++;
		finish_test;
	end
	initial begin
		repeat (2) @(posedge core_clk);
		rst_b <= 1;
		rd(`EIM_OFF_MASK, 0);
		wr(`EIM_OFF_MASK, 32'hffffffff);
		rd(`EIM_OFF_MASK, 0);
		wr(`EIM_OFF_ENABLE, 32'hffffffff);
		rd(`EIM_OFF_MASK, 32'h7cff);
		rd(`EIM_OFF_ENABLE, 0);
		foreach (rows[i]) begin
			v = 32'h1 << rows[i][0];
			wr(`EIM_OFF_ENABLE, v);
			ev <= v[14:0];
			rd(`EIM_OFF_PEEK, rows[i][1] ? v : 32'h0);
			ev <= 0;
			repeat (3) @(posedge core_clk);
			#1 chk({31'h0, mac_irq}, 32'h1);
			wr(`EIM_OFF_DISABLE, v);
			#1 chk({31'h0, mac_irq}, 32'h0);
			rd(`EIM_OFF_STATUS, v);
		end
		rd(`EIM_OFF_MASK, 0);
		rd(`EIM_OFF_STATUS, 0);
		@(posedge core_clk) clk_en <= 0;
		wr(`EIM_OFF_ENABLE, 32'h7cff);
		clk_en <= 1;
		rd(`EIM_OFF_MASK, 0);
		wr(`EIM_OFF_ENABLE, 32'h7cff);
		rst_b <= 0;
		@(posedge core_clk) rst_b <= 1;
		rd(`EIM_OFF_MASK, 0);
		wr(`EIM_OFF_ENABLE, 32'h7cff);
		wr(`EIM_OFF_DISABLE, 32'h7cff);
		rd(`EIM_OFF_MASK, 0);
		// Clear register drops only the chosen flag
		ev <= 15'h0081;
		@(posedge core_clk) ev <= 0;
		wr(`EIM_OFF_CLEAR, 32'h1);
		rd(`EIM_OFF_PEEK, 32'h80);
		#1 chk({31'h0, mac_irq}, 32'h0);
		// An event in the clearing read cycle survives the clear
		ev <= 15'h0004;
		rd(`EIM_OFF_STATUS, 32'h84);
		ev <= 0;
		rd(`EIM_OFF_PEEK, 32'h4);
		rd(`EIM_OFF_STATUS, 32'h4);
		rd(`EIM_OFF_STATUS, 0);
		rd(`EIM_OFF_DISABLE, 0);
		finish_test;
	end
endmodule // tb_eim_irq_mask
`default_nettype wire
